/* File: dv/arb_bank_monitor.sv */
// port assertions for the converter result register bank
`default_nettype none
module arb_bank_monitor
(
	input  wire logic       sys_clk,
	input  wire logic       rst_b,
	input  wire logic       reg_reset,
	input  wire logic       watchdog_expired,
	input  wire logic       conv_enable,
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	input  wire logic [7:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	input  wire logic [7:0] reg_rdata,
	input  wire logic       reg_rvalid,
	input  wire logic       conv_busy,
	input  wire logic       dplus_conv_off,
	input  wire logic       dminus_conv_off
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_b);
	chk_read_answered:
		assert property (reg_rd |=> reg_rvalid) else $error("read not answered");
	chk_answer_cause:
		assert property (reg_rvalid |-> $past(reg_rd)) else $error("stray read answer");
	chk_low_nibble:
		assert property (reg_rd && reg_addr == 8'h30 |=> reg_rdata[3:0] == 4'h0)
			else $error("reserved bits not zero");
	chk_dplus_write:
		assert property (reg_wr && reg_addr == 8'h30 && !reg_reset
			|=> dplus_conv_off == $past(reg_wdata[7])) else $error("bit 7 not written");
	chk_dminus_write:
		assert property (reg_wr && reg_addr == 8'h30 && !reg_reset
			|=> dminus_conv_off == $past(reg_wdata[6])) else $error("bit 6 not written");
	chk_cmd_clears:
		assert property (reg_reset |=> !dplus_conv_off && !dminus_conv_off)
			else $error("disable bits survive reset command");
	chk_bits_hold:
		assert property (!(reg_wr && reg_addr == 8'h30) && !reg_reset
			|=> $stable({dplus_conv_off, dminus_conv_off})) else $error("disable bits moved");
	chk_enable_gate:
		assert property ((!conv_enable || watchdog_expired) [*3] |-> !conv_busy)
			else $error("scan runs without enable");
endmodule
bind arb_bank arb_bank_monitor u_mon (.sys_clk, .rst_b, .reg_reset, .watchdog_expired,
	.conv_enable, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .reg_rvalid,
	.conv_busy, .dplus_conv_off, .dminus_conv_off);
`default_nettype wire

/* File: dv/arb_bank_tb.sv */
// self-checking bench for the converter result register bank
`default_nettype none
`define CHK(got, want) \
	begin \
		total_checks++; \
		if ((got) !== (want)) \
		begin \
			errors++; \
			$display("[ERR] %0t got %h exp %h", $time, got, want); \
		end \
	end
module arb_bank_tb;
	import arb_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	logic        sys_clk, rst_b, reg_reset, watchdog_expired, conv_enable, one_shot;
	logic        battery_discharge_sense_on, forward_charging, input_current_reverse;
	logic        sample_ready, reg_wr, reg_rd, reg_rvalid, conv_busy;
	logic        dplus_conv_off, dminus_conv_off;
	logic [15:0] sample_magnitude, base, w;
	logic [15:0] held [8];
	logic [2:0]  conv_channel;
	logic [7:0]  reg_addr, reg_wdata, reg_rdata, b8;
	logic [7:0]  ofs [8];
	int          errors, total_checks;
	arb_bank u_dut (.sys_clk, .rst_b, .reg_reset, .watchdog_expired, .conv_enable,
		.one_shot, .battery_discharge_sense_on, .forward_charging, .input_current_reverse,
		.sample_ready, .sample_magnitude, .dplus_sample_ready(1'b0),
		.dminus_sample_ready(1'b0), .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata,
		.reg_rvalid, .conv_busy, .conv_channel, .dplus_conv_off, .dminus_conv_off);
	arb_sample_src u_src (.sys_clk, .rst_b, .conv_busy, .base, .sample_ready,
		.sample_magnitude);
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] v);
		@(posedge sys_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1;
		`CHK(reg_rvalid, 1'b1)
		v = reg_rdata;
	endtask
	// high byte first: it freezes the low byte for the following read
	task automatic rd16(input logic [7:0] a, output logic [15:0] v);
		rd(a, v[15:8]);
		rd(a + 8'h01, v[7:0]);
	endtask
	task automatic run_pass(input logic [15:0] b, input logic rev, fwd, dis, skip);
		logic [15:0] v;
		logic [15:0] want;
		@(posedge sys_clk);
		base <= b;
		input_current_reverse <= rev;
		forward_charging <= fwd;
		battery_discharge_sense_on <= dis;
		conv_enable <= 1'b1;
		for (int n = 0; n < 50 && !conv_busy; n++) @(negedge sys_clk);
		`CHK(conv_busy, 1'b1)
		for (int n = 0; n < 400 && conv_busy; n++) @(negedge sys_clk);
		repeat (20) @(negedge sys_clk);
		`CHK(conv_busy, 1'b0)
		@(posedge sys_clk);
		conv_enable <= 1'b0;
		for (int k = 0; k < 8; k++)
		begin
			rd16(ofs[k], v);
			want = b + 16'(k);
			if (k == 0 && rev)
				want = -want;
			if (k == 1 && !fwd)
				want = dis ? -want : held[1];
			if ((k == 3 || k == 4) && skip)
				want = held[k];
			held[k] = want;
			`CHK(v, want)
		end
		$display("scan pass %h done", b);
	endtask
	task automatic final_report;
		$display("checks %0d errors %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	initial
	begin
		sys_clk = 1'b0;
		forever #2 sys_clk = ~sys_clk;
	end
	initial
	begin
		#20000;
		errors++;
		final_report;
	end
	initial
	begin
		{rst_b, reg_reset, watchdog_expired, conv_enable, reg_wr, reg_rd} = '0;
		{battery_discharge_sense_on, forward_charging, input_current_reverse} = '0;
		{reg_addr, reg_wdata, base} = '0;
		held = '{default: 16'h0000};
		one_shot = 1'b1;
		errors = 0;
		total_checks = 0;
		ofs = '{8'h31, 8'h33, 8'h35, 8'h37, 8'h39, 8'h3B, 8'h3D, 8'h3F};
		repeat (3) @(posedge sys_clk);
		rst_b <= 1'b1;
		foreach (ofs[k])
		begin
			rd16(ofs[k], w);
			`CHK(w, 16'h0000)
		end
		rd(8'h30, b8);
		`CHK(b8, 8'h00)
		$display("reset values done");
		wr(8'h30, 8'hFF);
		rd(8'h30, b8);
		`CHK(b8, 8'hF0)
		`CHK({dplus_conv_off, dminus_conv_off}, 2'b11)
		wr(8'h31, 8'h55);
		rd(8'h31, b8);
		`CHK(b8, 8'h00)
		@(posedge sys_clk);
		reg_reset <= 1'b1;
		@(posedge sys_clk);
		reg_reset <= 1'b0;
		rd(8'h30, b8);
		`CHK(b8, 8'h00)
		`CHK({dplus_conv_off, dminus_conv_off}, 2'b00)
		$display("disable register done");
		@(posedge sys_clk);
		watchdog_expired <= 1'b1;
		conv_enable <= 1'b1;
		repeat (10) @(negedge sys_clk);
		`CHK(conv_busy, 1'b0)
		@(posedge sys_clk);
		watchdog_expired <= 1'b0;
		conv_enable <= 1'b0;
		$display("watchdog gate done");
		run_pass(16'h0100, 1'b0, 1'b1, 1'b0, 1'b0);
		run_pass(16'h0200, 1'b1, 1'b0, 1'b1, 1'b0);
		wr(8'h30, 8'h30);
		`CHK({dplus_conv_off, dminus_conv_off}, 2'b00)
		run_pass(16'h0300, 1'b0, 1'b0, 1'b0, 1'b1);
		@(posedge sys_clk);
		one_shot <= 1'b0;
		base <= 16'h0400;
		conv_enable <= 1'b1;
		for (int n = 0; n < 100 && conv_channel != 3'h7; n++) @(negedge sys_clk);
		`CHK(conv_channel, 3'h7)
		repeat (20) @(negedge sys_clk);
		`CHK(conv_busy, 1'b1)
		`CHK(conv_channel, 3'h0)
		@(posedge sys_clk);
		conv_enable <= 1'b0;
		repeat (4) @(negedge sys_clk);
		`CHK(conv_busy, 1'b0)
		$display("continuous scan done");
		final_report;
	end
endmodule
`default_nettype wire

/* File: dv/arb_sample_src.sv */
// converter front-end model: one sample per channel while a scan runs
`default_nettype none
module arb_sample_src
(
	input  wire logic        sys_clk,
	input  wire logic        rst_b,
	input  wire logic        conv_busy,
	input  wire logic [15:0] base,
	output logic             sample_ready,
	output logic      [15:0] sample_magnitude
);
	logic [1:0] gap;
	logic [3:0] idx;
	// slow on purpose so the scan must wait; data toggles between samples
	always_ff @(posedge sys_clk)
	begin
		gap <= rst_b ? gap + 2'h1 : 2'h0;
		sample_ready <= 1'b0;
		sample_magnitude <= rst_b ? ~sample_magnitude : 16'h0000;
		if (!rst_b || !conv_busy)
			idx <= 4'h0;
		else if (gap == 2'h3 && idx < 4'h8)
		begin
			sample_ready <= 1'b1;
			sample_magnitude <= base + 16'(idx);
			idx <= idx + 4'h1;
		end
	end
endmodule
`default_nettype wire

/* File: logic/arb_bank.sv */
// converter channel-disable register and result registers with host access
`default_nettype none
module arb_bank
	import arb_pkg::*;
(
	input  wire logic        sys_clk,
	input  wire logic        rst_b,
	input  wire logic        reg_reset,
	input  wire logic        watchdog_expired,
	input  wire logic        conv_enable,
	input  wire logic        one_shot,
	input  wire logic        battery_discharge_sense_on,
	input  wire logic        forward_charging,
	input  wire logic        input_current_reverse,
	input  wire logic        sample_ready,
	input  wire logic [15:0] sample_magnitude,
	input  wire logic        dplus_sample_ready,
	input  wire logic        dminus_sample_ready,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	input  wire logic [7:0]  reg_addr,
	input  wire logic [7:0]  reg_wdata,
	output logic      [7:0]  reg_rdata,
	output logic             reg_rvalid,
	output logic             conv_busy,
	output logic      [2:0]  conv_channel,
	output logic             dplus_conv_off,
	output logic             dminus_conv_off
);
	typedef struct packed
	{
		logic [7:0]                   disable_reg;
		logic [ARB_NUM_CH-1:0][15:0]  result;
		logic [7:0]                   shadow_low;
		logic [7:0]                   rdata;
		logic                         rvalid;
		logic                         busy;
		logic [2:0]                   channel;
		logic                         en_master;
	} arb_bank_st_t;

	arb_bank_st_t cur;
	arb_bank_st_t next_cur;
	logic         scan_active;
	logic [2:0]   scan_ch;
	logic         scan_take;
	logic         conv_run;
	logic [15:0]  signed_iin;
	logic [15:0]  signed_ibat;
	logic         ibat_reverse;
	logic         ibat_valid;

	// maps a byte address to channel index and word half; hit low means unmapped
	function automatic logic [4:0] arb_decode(input logic [7:0] a);
		logic [4:0] r;
		r = 5'h00;
		if (a >= ARB_OFS_IIN && a <= (ARB_OFS_TS + 8'h01))
		begin
			r[4] = 1'b1;
			r[3] = a[0] ^ ARB_OFS_IIN[0];
			r[2:0] = 3'((a - ARB_OFS_IIN) >> 1);
		end
		return r;
	endfunction

	// the stored enable lags one cycle, so expiry and reset command also gate directly
	assign conv_run = cur.en_master && conv_enable && !watchdog_expired && !reg_reset;

	arb_seq u_seq
	(
		.sys_clk      (sys_clk),
		.rst_b        (rst_b),
		.conv_on      (conv_run),
		.one_shot     (one_shot),
		.sample_ready (sample_ready),
		.scan_active  (scan_active),
		.scan_ch      (scan_ch),
		.scan_take    (scan_take)
	);

	// the host-visible sign of the input current follows flow direction
	arb_sign u_sign_iin
	(
		.magnitude (sample_magnitude),
		.reverse   (input_current_reverse),
		.value     (signed_iin)
	);

	assign ibat_reverse = !forward_charging;
	assign ibat_valid = forward_charging || battery_discharge_sense_on;

	arb_sign u_sign_ibat
	(
		.magnitude (sample_magnitude),
		.reverse   (ibat_reverse),
		.value     (signed_ibat)
	);

	always_comb
	begin
		logic [4:0] dec;
		logic [15:0] word;
		dec = arb_decode(reg_addr);
		word = cur.result[dec[2:0]];
		next_cur = cur;
		next_cur.rvalid = 1'b0;
		next_cur.busy = scan_active;
		next_cur.channel = scan_ch;
		if (watchdog_expired)
			next_cur.en_master = 1'b0;
		else
			next_cur.en_master = 1'b1;
		if (scan_take)
		begin
			unique case (scan_ch)
				ARB_CH_IIN:
					next_cur.result[ARB_CH_IIN] = signed_iin;
				ARB_CH_IBAT:
				begin
					if (ibat_valid)
						next_cur.result[ARB_CH_IBAT] = signed_ibat;
				end
				ARB_CH_VIN1:
				begin
					if (!cur.disable_reg[ARB_BIT_IN1])
						next_cur.result[ARB_CH_VIN1] = sample_magnitude;
				end
				ARB_CH_VIN2:
				begin
					if (!cur.disable_reg[ARB_BIT_IN2])
						next_cur.result[ARB_CH_VIN2] = sample_magnitude;
				end
				ARB_CH_VBUS:
					next_cur.result[ARB_CH_VBUS] = sample_magnitude;
				ARB_CH_VBAT:
					next_cur.result[ARB_CH_VBAT] = sample_magnitude;
				ARB_CH_VSYS:
					next_cur.result[ARB_CH_VSYS] = sample_magnitude;
				ARB_CH_TS:
					next_cur.result[ARB_CH_TS] = sample_magnitude;
			endcase
		end
		if (reg_wr && reg_addr == ARB_OFS_DISABLE)
			next_cur.disable_reg = reg_wdata & ARB_DISABLE_WMASK;
		if (reg_rd)
		begin
			next_cur.rvalid = 1'b1;
			if (reg_addr == ARB_OFS_DISABLE)
				next_cur.rdata = cur.disable_reg & ARB_DISABLE_WMASK;
			else if (dec[4] && !dec[3])
			begin
				// high byte read freezes the low byte so the pair is coherent
				next_cur.rdata = word[15:8];
				next_cur.shadow_low = word[7:0];
			end
			else if (dec[4])
				next_cur.rdata = cur.shadow_low;
			else
				next_cur.rdata = ARB_READ_UNMAPPED;
		end
		if (reg_reset)
		begin
			next_cur.disable_reg = ARB_DISABLE_RESET;
			next_cur.en_master = 1'b0;
		end
	end

	always_ff @(posedge sys_clk)
	begin
		if (!rst_b)
		begin
			cur.disable_reg <= ARB_DISABLE_RESET;
			cur.result <= '0;
			cur.shadow_low <= 8'h00;
			cur.rdata <= 8'h00;
			cur.rvalid <= 1'b0;
			cur.busy <= 1'b0;
			cur.channel <= 3'h0;
			cur.en_master <= 1'b0;
		end
		else
			cur <= next_cur;
	end

	// the D+/D- results live elsewhere; only their off switches leave here
	logic unused_dpdm;
	assign unused_dpdm = dplus_sample_ready ^ dminus_sample_ready;

	assign reg_rdata = cur.rdata;
	assign reg_rvalid = cur.rvalid;
	assign conv_busy = cur.busy;
	assign conv_channel = cur.channel;
	assign dplus_conv_off = cur.disable_reg[ARB_BIT_DPLUS];
	assign dminus_conv_off = cur.disable_reg[ARB_BIT_DMINUS];
endmodule
`default_nettype wire

/* File: logic/arb_pkg.sv */
// constants and types shared by the converter result register bank
`default_nettype none
package arb_pkg;
	localparam logic [7:0] ARB_OFS_DISABLE    = 8'h30;
	localparam logic [7:0] ARB_OFS_IIN        = 8'h31;
	localparam logic [7:0] ARB_OFS_IBAT       = 8'h33;
	localparam logic [7:0] ARB_OFS_VBUS       = 8'h35;
	localparam logic [7:0] ARB_OFS_VIN1       = 8'h37;
	localparam logic [7:0] ARB_OFS_VIN2       = 8'h39;
	localparam logic [7:0] ARB_OFS_VBAT       = 8'h3B;
	localparam logic [7:0] ARB_OFS_VSYS       = 8'h3D;
	localparam logic [7:0] ARB_OFS_TS         = 8'h3F;
	localparam logic [7:0] ARB_DISABLE_RESET  = 8'h00;
	localparam logic [7:0] ARB_DISABLE_WMASK  = 8'hF0;
	localparam int         ARB_BIT_DPLUS      = 7;
	localparam int         ARB_BIT_DMINUS     = 6;
	localparam int         ARB_BIT_IN2        = 5;
	localparam int         ARB_BIT_IN1        = 4;
	localparam logic [15:0] ARB_RESULT_RESET  = 16'h0000;
	localparam int         ARB_NUM_CH         = 8;
	localparam logic [2:0] ARB_CH_IIN         = 3'h0;
	localparam logic [2:0] ARB_CH_IBAT        = 3'h1;
	localparam logic [2:0] ARB_CH_VBUS        = 3'h2;
	localparam logic [2:0] ARB_CH_VIN1        = 3'h3;
	localparam logic [2:0] ARB_CH_VIN2        = 3'h4;
	localparam logic [2:0] ARB_CH_VBAT        = 3'h5;
	localparam logic [2:0] ARB_CH_VSYS        = 3'h6;
	localparam logic [2:0] ARB_CH_TS          = 3'h7;
	localparam logic [7:0] ARB_READ_UNMAPPED  = 8'h00;
	typedef enum logic [2:0]
	{
		ARB_IDLE = 3'b001,
		ARB_RUN  = 3'b010,
		ARB_DONE = 3'b100
	} arb_state_t;
endpackage
`default_nettype wire

/* File: logic/arb_seq.sv */
// conversion sequencer: continuous or single-pass scan over all eight channels
`default_nettype none
module arb_seq
	import arb_pkg::*;
(
	input  wire logic        sys_clk,
	input  wire logic        rst_b,
	input  wire logic        conv_on,
	input  wire logic        one_shot,
	input  wire logic        sample_ready,
	output logic             scan_active,
	output logic      [2:0]  scan_ch,
	output logic             scan_take
);
	typedef struct packed
	{
		arb_state_t  state;
		logic [2:0]  ch;
	} arb_seq_st_t;
	arb_seq_st_t cur;
	arb_seq_st_t next_cur;
	always_comb
	begin
		next_cur = cur;
		scan_take = 1'b0;
		unique case (cur.state)
			ARB_IDLE:
			begin
				next_cur.ch = 3'h0;
				if (conv_on)
					next_cur.state = ARB_RUN;
			end
			ARB_RUN:
			begin
				if (!conv_on)
					next_cur.state = ARB_IDLE;
				else if (sample_ready)
				begin
					scan_take = 1'b1;
					next_cur.ch = cur.ch + 3'h1;
					if (cur.ch == 3'(ARB_NUM_CH - 1) && one_shot)
						next_cur.state = ARB_DONE;
				end
			end
			ARB_DONE:
			begin
				// a single pass ends here until the converter is switched off
				if (!conv_on)
					next_cur.state = ARB_IDLE;
			end
			default:
				next_cur.state = ARB_IDLE;
		endcase
	end
	always_ff @(posedge sys_clk)
	begin
		if (!rst_b)
		begin
			cur.state <= ARB_IDLE;
			cur.ch <= 3'h0;
		end
		else
			cur <= next_cur;
	end
	assign scan_active = (cur.state == ARB_RUN);
	assign scan_ch = cur.ch;
endmodule
`default_nettype wire

/* File: logic/arb_sign.sv */
// folds a magnitude and direction into a two's-complement current reading
`default_nettype none
module arb_sign
(
	input  wire logic [15:0] magnitude,
	input  wire logic        reverse,
	output logic      [15:0] value
);
	always_comb
	begin
		value = reverse ? (16'h0000 - magnitude) : magnitude;
	end
endmodule
`default_nettype wire
